/* File: verilog/ccalq_pkg.sv */
// shared constants and types for the clear-channel and link-quality block
package ccalq_pkg;

  // ----------------------------------------------------------------
  // register map (word offsets are byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_MODEM_CONTROL_0 = 4'h0;
  localparam logic [3:0] ADDR_IO_CONFIG_0     = 4'h4;
  localparam logic [3:0] ADDR_SENSE_CONFIG    = 4'h8;
  localparam logic [3:0] ADDR_STATUS          = 4'hC;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MODE_LSB   = 6;
  localparam int HYST_LSB   = 2;
  localparam int AUTOFC_BIT = 5;
  localparam int INVERT_BIT = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] RST_MODE      = 2'h3;
  localparam logic [2:0] RST_HYST      = 3'h2;
  localparam logic       RST_AUTOFC    = 1'b1;
  localparam logic       RST_INVERT    = 1'b0;
  localparam logic [7:0] RST_THRESHOLD = 8'hE0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 25;
  localparam int SYMBOL_NS        = 16000;
  localparam int SYMBOL_CYCLES    = (SYMBOL_NS * CLK_MHZ) / 1000;
  localparam int VALID_SYMBOLS    = 8;
  localparam int AVERAGE_CORRELATION_VALUE_SYMBOLS     = 8;
  localparam logic [3:0] SYM_CNT_MAX = 4'h8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CCALQ_MODE_RSVD,
    CCALQ_MODE_ENERGY,
    CCALQ_MODE_NOFRAME,
    CCALQ_MODE_BOTH
  } ccalq_mode_t;

  // one demodulated symbol from the receive path
  typedef struct packed {
    logic       symbolStrobe;
    logic [6:0] correlation;
    logic [7:0] energy;
  } ccalq_symbol_t;

  // status appended to a received frame in place of the checksum
  typedef struct packed {
    logic [7:0] signalStrength;
    logic       checkPass;
    logic [6:0] averageCorrelation;
  } ccalq_trailer_t;

endpackage

/* File: verilog/ccalq_avg8.sv */
// eight-entry running average of signed strength samples
`timescale 1ns/1ps
`default_nettype none
module ccalq_avg8 (
  // clock and control
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              clkEn,
  input  wire logic              clear,
  // samples
  input  wire logic              sampleValid,
  input  wire logic signed [7:0] sample,
  // result, registered
  output logic signed [7:0]      average
);
  logic signed [7:0]  sampleMem [0:7];
  logic        [2:0]  wrPtr_reg;
  logic signed [10:0] sum_reg;
  logic signed [10:0] sum_next;

  assign sum_next = sum_reg + 11'(sample) - 11'(sampleMem[wrPtr_reg]);

  // ----------------------------------------------------------------
  // sample store
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : gEntry
      always_ff @(posedge clk) begin
        if (reset || (clkEn && clear)) begin
          sampleMem[gi] <= 8'sh00;
        end else if (clkEn && sampleValid && wrPtr_reg == 3'(gi)) begin
          sampleMem[gi] <= sample;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (reset) begin
      wrPtr_reg <= 3'h0;
      sum_reg   <= 11'sh000;
      average   <= 8'sh00;
    end else if (clkEn) begin
      if (clear) begin
        wrPtr_reg <= 3'h0;
        sum_reg   <= 11'sh000;
        average   <= 8'sh00;
      end else if (sampleValid) begin
        wrPtr_reg <= wrPtr_reg + 3'h1;
        sum_reg   <= sum_next;
        average   <= 8'(sum_next >>> 3);
      end
    end
  end
endmodule
`default_nettype wire

/* File: verilog/ccalq_top.sv */
// clear-channel assessment and link-quality measurement block
// Notes on behaviour
// - clear decision compares averaged strength with a 1 dB step threshold
// - clear indication only valid after eight symbols of receiver enable
// - hysteresis in modem control bits applies to the clear decision
// - mode 1 energy, 2 no frame, 3 both, 0 reserved
// - clear pin high when clear, inverted by the invert bit
// - transmit-if-clear starts transmission only if the channel is clear
// - transmit-active status bit tells host whether transmission began
// - unsigned 7-bit average correlation over first eight symbols after SFD
// - with auto frame check, trailer replaces checksum with quality data
// - correlation near 110 best frames, near 50 weakest detectable
// - strength is signed 8-bit, averaged over eight symbol periods
// - strength-valid flag rises once averaging has enough symbols
// - after valid, strength register updates once per symbol
`timescale 1ns/1ps
`default_nettype none
module ccalq_top
  import ccalq_pkg::*;
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic                      clkEn,
  // avalon-mm slave
  input  wire logic [3:0]                avsAddress,
  input  wire logic                      avsRead,
  input  wire logic                      avsWrite,
  input  wire logic [31:0]               avsWriteData,
  input  wire logic [3:0]                avsByteEnable,
  output logic [31:0]                    avsReadData,
  output logic                           avsWaitRequest,
  // receive path
  input  wire logic                      rxEnable,
  input  wire ccalq_pkg::ccalq_symbol_t  rxSymbol,
  input  wire logic                      frameStart,
  input  wire logic                      frameActive,
  input  wire logic                      frameEnd,
  input  wire logic                      frameCheckOk,
  // transmit control
  input  wire logic                      transmit_if_clear_strobe,
  input  wire logic                      txDone,
  output logic                           txStart,
  // clear-channel pin and frame trailer
  output logic                           clearChannelPin,
  output ccalq_pkg::ccalq_trailer_t      frameTrailer,
  output logic                           frameTrailerValid
);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [1:0] clear_assess_mode_select_reg;
  logic [2:0] clear_assess_hysteresis_reg;
  logic       auto_frame_check_enable_reg;
  logic       clear_pin_invert_reg;
  logic [7:0] carrier_sense_threshold_reg;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0]        enableSymbols_reg;
  logic              signal_strength_valid_flag_reg;
  logic signed [7:0] signal_strength_value_reg;
  logic              energyClear_reg;
  logic              txActive_reg;
  logic [3:0]        corrCount_reg;
  logic [9:0]        corrSum_reg;
  logic [6:0]        average_correlation_value_reg;
  logic              readPending_reg;
  logic signed [7:0] averageStrength;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire selModem  = avsAddress == ADDR_MODEM_CONTROL_0;
  wire selIo     = avsAddress == ADDR_IO_CONFIG_0;
  wire selSense  = avsAddress == ADDR_SENSE_CONFIG;
  wire selStatus = avsAddress == ADDR_STATUS;
  wire wrLow     = clkEn && avsWrite && avsByteEnable[0];
  wire wrHigh    = clkEn && avsWrite && avsByteEnable[1];

  // one wait state on reads so read data come from a register
  assign avsWaitRequest = avsRead && !readPending_reg;

  wire [31:0] modemWord = {24'h000000, clear_assess_mode_select_reg,
                           auto_frame_check_enable_reg,
                           clear_assess_hysteresis_reg, 2'h0};
  wire [31:0] ioWord    = {31'h00000000, clear_pin_invert_reg};
  wire [31:0] senseWord = {16'h0000, carrier_sense_threshold_reg,
                           signal_strength_value_reg};
  wire [31:0] statusWord = {16'h0000, 1'b0,
                            average_correlation_value_reg,
                            4'h0, enableSymbols_reg == SYM_CNT_MAX,
                            energyClear_reg, txActive_reg,
                            signal_strength_valid_flag_reg};
  // unmapped addresses read as zero
  wire [31:0] readMux = selModem  ? modemWord  :
                        selIo     ? ioWord     :
                        selSense  ? senseWord  :
                        selStatus ? statusWord : 32'h00000000;

  always_ff @(posedge clk) begin
    if (reset) begin
      readPending_reg <= 1'b0;
      avsReadData     <= 32'h00000000;
    end else if (clkEn) begin
      readPending_reg <= avsRead && !readPending_reg;
      if (avsRead && !readPending_reg) begin
        avsReadData <= readMux;
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      clear_assess_mode_select_reg <= RST_MODE;
      clear_assess_hysteresis_reg  <= RST_HYST;
      auto_frame_check_enable_reg  <= RST_AUTOFC;
      clear_pin_invert_reg         <= RST_INVERT;
      carrier_sense_threshold_reg  <= RST_THRESHOLD;
    end else begin
      if (wrLow && selModem) begin
        clear_assess_mode_select_reg <= avsWriteData[MODE_LSB +: 2];
        clear_assess_hysteresis_reg  <= avsWriteData[HYST_LSB +: 3];
        auto_frame_check_enable_reg  <= avsWriteData[AUTOFC_BIT];
      end
      if (wrLow && selIo) begin
        clear_pin_invert_reg <= avsWriteData[INVERT_BIT];
      end
      if (wrHigh && selSense) begin
        carrier_sense_threshold_reg <= avsWriteData[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // receiver enable timing
  // ----------------------------------------------------------------
  wire symTick   = rxSymbol.symbolStrobe;
  wire rxSettled = enableSymbols_reg == SYM_CNT_MAX;

  always_ff @(posedge clk) begin
    if (reset) begin
      enableSymbols_reg <= 4'h0;
    end else if (clkEn) begin
      if (!rxEnable) begin
        enableSymbols_reg <= 4'h0;
      end else if (symTick && !rxSettled) begin
        enableSymbols_reg <= enableSymbols_reg + 4'h1;
      end
    end
  end

  // averaging restarts whenever the receiver drops
  ccalq_avg8 uAvg (
    .clk         (clk),
    .reset       (reset),
    .clkEn       (clkEn),
    .clear       (!rxEnable),
    .sampleValid (rxEnable && symTick),
    .sample      (rxSymbol.energy),
    .average     (averageStrength)
  );

  // ----------------------------------------------------------------
  // signal strength and energy decision
  // ----------------------------------------------------------------
  wire signed [9:0] thrWide  = 10'(signed'(carrier_sense_threshold_reg));
  wire signed [9:0] hystWide = 10'({1'b0, clear_assess_hysteresis_reg});
  wire signed [9:0] strWide  = 10'(signed'(signal_strength_value_reg));
  // separate rise and fall points keep the decision from chattering
  wire goBusy  = strWide >  thrWide + hystWide;
  wire goClear = strWide <  thrWide - hystWide;

  always_ff @(posedge clk) begin
    if (reset) begin
      signal_strength_valid_flag_reg <= 1'b0;
      signal_strength_value_reg      <= 8'sh00;
      energyClear_reg                <= 1'b0;
    end else if (clkEn) begin
      signal_strength_valid_flag_reg <= rxEnable && rxSettled;
      if (rxEnable && rxSettled && symTick) begin
        signal_strength_value_reg <= averageStrength;
      end
      if (!signal_strength_valid_flag_reg) begin
        energyClear_reg <= 1'b0;
      end else if (goClear) begin
        energyClear_reg <= 1'b1;
      end else if (goBusy) begin
        energyClear_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // mode decode and clear result
  // ----------------------------------------------------------------
  ccalq_mode_t modeSel;
  logic        modeClear;
  assign modeSel = ccalq_mode_t'(clear_assess_mode_select_reg);

  always_comb begin
    case (modeSel)
      CCALQ_MODE_ENERGY:  modeClear = energyClear_reg;
      CCALQ_MODE_NOFRAME: modeClear = !frameActive;
      CCALQ_MODE_BOTH:    modeClear = energyClear_reg && !frameActive;
      default:            modeClear = 1'b0;
    endcase
  end

  // reserved mode reports busy so nothing transmits on a bad setting
  wire channelClear = signal_strength_valid_flag_reg && modeClear;

  always_ff @(posedge clk) begin
    if (reset) begin
      clearChannelPin <= 1'b0;
    end else if (clkEn) begin
      clearChannelPin <= channelClear ^ clear_pin_invert_reg;
    end
  end

  // ----------------------------------------------------------------
  // transmit if clear
  // ----------------------------------------------------------------
  wire txGrant = transmit_if_clear_strobe && channelClear && !txActive_reg;
  assign txStart = clkEn && txGrant;

  always_ff @(posedge clk) begin
    if (reset) begin
      txActive_reg <= 1'b0;
    end else if (clkEn) begin
      if (txGrant) begin
        txActive_reg <= 1'b1;
      end else if (txDone) begin
        txActive_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // correlation average over the first symbols after the delimiter
  // ----------------------------------------------------------------
  wire corrRun  = corrCount_reg != SYM_CNT_MAX[3:0] && frameActive;
  wire corrLast = corrRun && symTick && corrCount_reg == 4'h7;
  // sum of eight 7-bit values, shifted down keeps 7 unsigned bits
  wire [9:0] corrSumNext = corrSum_reg + 10'(rxSymbol.correlation);

  always_ff @(posedge clk) begin
    if (reset) begin
      corrCount_reg                 <= SYM_CNT_MAX;
      corrSum_reg                   <= 10'h000;
      average_correlation_value_reg <= 7'h00;
    end else if (clkEn) begin
      if (frameStart) begin
        corrCount_reg <= 4'h0;
        corrSum_reg   <= 10'h000;
      end else if (corrRun && symTick) begin
        corrCount_reg <= corrCount_reg + 4'h1;
        corrSum_reg   <= corrSumNext;
        if (corrLast) begin
          // raw correlator scale: ~110 best, ~50 weakest
          average_correlation_value_reg <= corrSumNext[9:3];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // frame trailer
  // ----------------------------------------------------------------
  // a frame shorter than eight symbols carries the previous average
  always_ff @(posedge clk) begin
    if (reset) begin
      frameTrailer      <= '0;
      frameTrailerValid <= 1'b0;
    end else if (clkEn) begin
      frameTrailerValid <= frameEnd && auto_frame_check_enable_reg;
      if (frameEnd && auto_frame_check_enable_reg) begin
        frameTrailer.signalStrength     <= signal_strength_value_reg;
        frameTrailer.checkPass          <= frameCheckOk;
        frameTrailer.averageCorrelation <= average_correlation_value_reg;
      end
    end
  end

endmodule
`default_nettype wire

/* File: testbench/ccalq_rx_model.sv */
// receive-path symbol source standing in for the demodulator
`timescale 1ns/1ps
`default_nettype none
module ccalq_rx_model
  import ccalq_pkg::*;
(
  // clock and control
  input  wire logic               clk,
  input  wire logic               run,
  // symbol content
  input  wire logic [7:0]         energy,
  input  wire logic [6:0]         average_correlation_value,
  // symbol stream
  output ccalq_pkg::ccalq_symbol_t sym
);
  logic [1:0] phase_reg = 2'h0;
  wire logic  strobe = run && (phase_reg == 2'h3);
  always_ff @(posedge clk) begin
    phase_reg <= phase_reg + 2'h1;
  end
  // fields are unqualified off the strobe, so show their inverse
  assign sym = {strobe, strobe ? average_correlation_value : ~average_correlation_value, strobe ? energy : ~energy};
endmodule
`default_nettype wire

/* File: testbench/ccalq_assertions.sv */
// concurrent checks on the clear-channel block ports
`timescale 1ns/1ps
`default_nettype none
module ccalq_checker
  import ccalq_pkg::*;
(
  // clock and reset
  input wire logic                      clk,
  input wire logic                      reset,
  input wire logic                      clkEn,
  // bus handshake
  input wire logic                      avsRead,
  input wire logic                      avsWrite,
  input wire logic                      avsWaitRequest,
  // receive, transmit and pin
  input wire logic                      rxEnable,
  input wire ccalq_pkg::ccalq_symbol_t  rxSymbol,
  input wire logic                      transmit_if_clear_strobe,
  input wire logic                      txStart,
  input wire logic                      clearChannelPin,
  // frame end and trailer
  input wire logic                      frameEnd,
  input wire logic                      frameCheckOk,
  input wire ccalq_pkg::ccalq_trailer_t frameTrailer,
  input wire logic                      frameTrailerValid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // symbols seen since the receiver came on, saturating at eight
  logic [3:0] symCnt_reg;
  logic [3:0] symCnt_next;
  assign symCnt_next = !rxEnable ? 4'h0 :
    (rxSymbol.symbolStrobe && clkEn && symCnt_reg != 4'h8) ?
    symCnt_reg + 4'h1 : symCnt_reg;
  always_ff @(posedge clk) begin
    symCnt_reg <= reset ? 4'h0 : symCnt_next;
  end
  tx_cause_a: assert property (txStart |-> transmit_if_clear_strobe && clkEn)
    else $error("transmit started without a request");
  early_tx_a: assert property (symCnt_reg < 4'h8 |-> !txStart)
    else $error("transmit started before eight symbols");
  reset_quiet_a: assert property ($past(reset) |-> !clearChannelPin && !txStart)
    else $error("pin or transmit active right after reset");
  write_nowait_a: assert property (avsWrite |-> !avsWaitRequest)
    else $error("write was stalled");
  read_answer_a: assert property ($rose(avsRead) |-> avsWaitRequest ##1 !avsWaitRequest)
    else $error("read answer not in the second cycle");
  trailer_pulse_a: assert property (frameTrailerValid |=> !frameTrailerValid)
    else $error("trailer valid longer than one cycle");
  trailer_cause_a: assert property (frameTrailerValid |-> $past(frameEnd))
    else $error("trailer without a frame end");
  check_flag_a: assert property (frameTrailerValid |->
    frameTrailer.checkPass == $past(frameCheckOk))
    else $error("trailer check flag wrong");
  cover property (txStart);
  cover property (frameTrailerValid && frameTrailer.checkPass);
  cover property (avsRead && !avsWaitRequest);
endmodule
bind ccalq_top ccalq_checker i_chk (
  .clk(clk), .reset(reset), .clkEn(clkEn), .avsRead(avsRead),
  .avsWrite(avsWrite), .avsWaitRequest(avsWaitRequest),
  .rxEnable(rxEnable), .rxSymbol(rxSymbol),
  .transmit_if_clear_strobe(transmit_if_clear_strobe),
  .txStart(txStart), .clearChannelPin(clearChannelPin),
  .frameEnd(frameEnd), .frameCheckOk(frameCheckOk),
  .frameTrailer(frameTrailer), .frameTrailerValid(frameTrailerValid));
`default_nettype wire

/* File: testbench/test_clear_channel_and_link_quality.sv */
// self-checking bench for the clear-channel and link-quality block
`timescale 1ns/1ps
`default_nettype none
module test_clear_channel_and_link_quality;
  import ccalq_pkg::*;
  logic           clk, reset, avsRead, avsWrite, rxEnable, rxRun, pin;
  logic           frameStart, frameActive, frameEnd, frameCheckOk;
  logic           txReq, txDone, txStart, waitReq, trailerValid;
  logic [3:0]     avsAddress, avsByteEnable;
  logic [31:0]    avsWriteData, avsReadData, rd;
  logic [7:0]     energy;
  logic [6:0]     average_correlation_value;
  ccalq_symbol_t  sym;
  ccalq_trailer_t trailer;
  int             mismatches, samples_checked;
  ccalq_top i_dut (
    .clk(clk), .reset(reset), .clkEn(1'b1), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitRequest(waitReq), .rxEnable(rxEnable), .rxSymbol(sym),
    .frameStart(frameStart), .frameActive(frameActive),
    .frameEnd(frameEnd), .frameCheckOk(frameCheckOk),
    .transmit_if_clear_strobe(txReq), .txDone(txDone), .txStart(txStart),
    .clearChannelPin(pin), .frameTrailer(trailer),
    .frameTrailerValid(trailerValid));
  ccalq_rx_model i_rx (.clk(clk), .run(rxRun), .energy(energy),
    .average_correlation_value(average_correlation_value), .sym(sym));
  // ----------------------------------------------------------------
  // bus, stimulus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // holds the request until the edge that sees waitrequest low
  task automatic access(input logic wr, input logic [3:0] a,
                        input logic [31:0] d, input logic [3:0] be);
    int   n;
    logic w;
    @(posedge clk);
    avsAddress <= a;
    avsWriteData <= d;
    avsByteEnable <= be;
    avsWrite <= wr;
    avsRead <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      w = waitReq;
      n++;
    end while (w !== 1'b0 && n < 20);
    if (w !== 1'b0) check(32'h1, 32'h0);
    rd = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask
  task automatic expectReg(input logic [3:0] a, input logic [31:0] m,
                           input logic [31:0] e);
    access(1'b0, a, 32'h0, 4'hF);
    check(rd & m, e);
  endtask
  task automatic waitSyms(input int n);
    repeat (n) @(posedge clk iff sym.symbolStrobe);
    repeat (3) @(posedge clk);
  endtask
  task automatic pulseTx(input logic e);
    @(posedge clk);
    txReq <= 1'b1;
    #1 check({31'h0, txStart}, {31'h0, e});
    @(posedge clk);
    txReq <= 1'b0;
  endtask
  task automatic sendFrame(input logic [6:0] c, input logic ok);
    @(posedge clk);
    average_correlation_value <= c;
    frameStart <= 1'b1;
    frameActive <= 1'b1;
    @(posedge clk);
    frameStart <= 1'b0;
    repeat (8) @(posedge clk iff sym.symbolStrobe);
    frameEnd <= 1'b1;
    frameCheckOk <= ok;
    frameActive <= 1'b0;
    @(posedge clk);
    frameEnd <= 1'b0;
    frameCheckOk <= 1'b0;
    #1 check({31'h0, trailerValid}, 32'h1);
    check({16'h0, trailer}, {16'h0, 8'h9C, ok, c});
    expectReg(ADDR_STATUS, 32'h7F00, {17'h0, c, 8'h0});
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #(40 * 20000);
    mismatches++;
    summarize();
  end
  initial begin
    {reset, avsRead, avsWrite, rxEnable, rxRun, frameStart} = 6'h20;
    {frameActive, frameEnd, frameCheckOk, txReq, txDone} = 5'h0;
    {avsAddress, avsByteEnable, avsWriteData} = 40'h0;
    energy = 8'h9C;
    average_correlation_value = 7'h0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    expectReg(ADDR_MODEM_CONTROL_0, 32'hC0, 32'hC0);
    expectReg(ADDR_IO_CONFIG_0, 32'h1, 32'h0);
    expectReg(ADDR_SENSE_CONFIG, 32'hFF00, 32'hE000);
    expectReg(4'h2, 32'hFFFFFFFF, 32'h0);
    check({31'h0, pin}, 32'h0);
    $display("test reset values done");
    rxEnable <= 1'b1;
    rxRun <= 1'b1;
    waitSyms(4);
    pulseTx(1'b0);
    expectReg(ADDR_STATUS, 32'h1, 32'h0);
    check({31'h0, pin}, 32'h0);
    waitSyms(6);
    expectReg(ADDR_STATUS, 32'h5, 32'h5);
    expectReg(ADDR_SENSE_CONFIG, 32'hFF, 32'h9C);
    check({31'h0, pin}, 32'h1);
    pulseTx(1'b1);
    expectReg(ADDR_STATUS, 32'h2, 32'h2);
    pulseTx(1'b0);
    txDone <= 1'b1;
    @(posedge clk);
    txDone <= 1'b0;
    expectReg(ADDR_STATUS, 32'h2, 32'h0);
    $display("test assessment and transmit done");
    access(1'b1, ADDR_IO_CONFIG_0, 32'h1, 4'h1);
    repeat (3) @(posedge clk);
    check({31'h0, pin}, 32'h0);
    access(1'b1, ADDR_IO_CONFIG_0, 32'h0, 4'h1);
    access(1'b1, ADDR_MODEM_CONTROL_0, 32'hF0, 4'h1);
    access(1'b1, ADDR_SENSE_CONFIG, 32'h9B00, 4'h2);
    waitSyms(2);
    expectReg(ADDR_STATUS, 32'h4, 32'h4);
    access(1'b1, ADDR_SENSE_CONFIG, 32'h9000, 4'h2);
    waitSyms(2);
    expectReg(ADDR_STATUS, 32'h4, 32'h0);
    check({31'h0, pin}, 32'h0);
    access(1'b1, ADDR_SENSE_CONFIG, 32'hE000, 4'h2);
    $display("test threshold and hysteresis done");
    for (int m = 0; m < 4; m++) begin
      access(1'b1, ADDR_MODEM_CONTROL_0, 32'(m * 64 + 32), 4'h1);
      for (int f = 0; f < 2; f++) begin
        frameActive <= f[0];
        waitSyms(1);
        check({31'h0, pin}, {31'h0, m == 1 || (m > 1 && f == 0)});
      end
    end
    frameActive <= 1'b0;
    $display("test modes done");
    sendFrame(7'h6E, 1'b1);
    sendFrame(7'h32, 1'b0);
    $display("test frame trailer done");
    summarize();
  end
endmodule
`default_nettype wire
